// ### rcd_pkg.sv
// shared constants and types for the retimer channel datapath
`default_nettype none

package rcd_pkg;

  // rate modes; line and host always share one of these
  typedef enum logic [2:0] {
    RCD_LAN   = 3'h0,
    RCD_GBE   = 3'h1,
    RCD_OTU2  = 3'h2,
    RCD_OTU1E = 3'h3,
    RCD_OTU2E = 3'h4
  } rcd_mode_t;

  // negotiation states, gray along idle-wait-resolve-good
  typedef enum logic [1:0] {
    RCD_AN_IDLE    = 2'h0,
    RCD_AN_WAIT    = 2'h1,
    RCD_AN_RESOLVE = 2'h3,
    RCD_AN_GOOD    = 2'h2
  } rcd_an_state_t;

  // ability bit positions
  localparam int AB_1G  = 0;
  localparam int AB_10G = 1;

  // side / clock source indices
  localparam int SIDE_LINE    = 0;
  localparam int SIDE_HOST    = 1;
  localparam logic [1:0] CK_LINE_RX = 2'h0;
  localparam logic [1:0] CK_HOST_RX = 2'h1;
  localparam logic [1:0] CK_LINE_TX = 2'h2;
  localparam logic [1:0] CK_HOST_TX = 2'h3;

  // clock output dividers
  localparam logic [6:0] DIV_SHORT = 7'h20;
  localparam logic [6:0] DIV_LONG  = 7'h40;

  // square wave run length and loop filter shift
  localparam int SQ_RUN_DEF = 8;
  localparam int LPF_SHIFT  = 4;

  // values after reset
  localparam rcd_mode_t     RST_MODE = RCD_LAN;
  localparam rcd_an_state_t RST_AN   = RCD_AN_IDLE;

endpackage : rcd_pkg

`default_nettype wire

// ### rcd_channel_datapath.sv
// one retimer channel: elastic buffers, rate control, fir, clock outputs
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - each direction has its own small elastic buffer
// - transmit clock trim follows opposite recovered clock through low-pass loop
// - line data goes to host serializer and host data to line, identically
// - receivers hand words over with a per-word data-rate strobe
// - reference rate latched after reset: both pins low 156.25, hi only 125
// - line and host run the same rate mode of the five
// - negotiation runs on line side or host side, never both
// - negotiation picks 1.25 or 10.3125 and steers clock recovery rate
// - common abilities resolved by fixed priority, unshared modes rejected
// - management enables negotiation or forces a mode
// - parallel detection links partners without negotiation
// - fir taps are three flops on the serial bit clock
// - pre, main and post coefficients weight taps, summed to output level
// - test pattern is square wave with runs of eight ones
// - line pma loopback in 1G and 10G
// - host pma loopback in 1G and 10G
// - four clock outputs each select any recovered or transmit clock
// - clock outputs divide selected rate by 32 or 64
// - signal monitor works only in 10G modes
// - unity-gain monitor stops adaptation and zeroes dfe taps
// - receive and transmit of a channel share one rate mode
module rcd_channel_datapath #(
  parameter int DW     = 20,
  parameter int DEPTH  = 2,
  parameter int TW     = 12,
  parameter int SQ_RUN = rcd_pkg::SQ_RUN_DEF
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      rate_sel_hi,
  input  wire logic                      rate_sel_lo,
  output logic                           ref_is_125,
  output logic                           ref_sel_bad,
  input  wire logic [1:0][DW-1:0]        rx_data,
  input  wire logic [1:0]                rx_valid,
  output logic      [1:0]                rx_ready,
  output logic      [1:0][DW-1:0]        tx_data,
  output logic      [1:0]                tx_valid,
  input  wire logic [1:0]                tx_ready,
  output logic      [1:0][TW-1:0]        tx_trim,
  output logic      [1:0]                eb_recentre,
  input  wire logic                      line_pma_loopback,
  input  wire logic                      host_pma_loopback,
  input  wire rcd_pkg::rcd_mode_t        cfg_mode,
  input  wire logic                      an_enable,
  input  wire logic                      an_on_host,
  input  wire logic [1:0]                an_local_abil,
  input  wire logic                      an_page_valid,
  input  wire logic [1:0]                an_partner_abil,
  input  wire logic                      an_pd_valid,
  input  wire logic                      an_pd_10g,
  input  wire logic                      an_link_fail,
  output logic                           an_line_active,
  output logic                           an_host_active,
  output logic                           an_done,
  output rcd_pkg::rcd_mode_t             line_rate_mode,
  output rcd_pkg::rcd_mode_t             host_rate_mode,
  output logic                           clock_recovery_unit_10g,
  input  wire logic                      tx_ser_bit,
  input  wire logic                      tx_square_en,
  input  wire logic signed [5:0]         coef_pre,
  input  wire logic signed [5:0]         coef_main,
  input  wire logic signed [5:0]         coef_post,
  output logic signed [7:0]              fir_level,
  output logic                           fir_clk_10g,
  input  wire logic [3:0][1:0]           ck_src_sel,
  input  wire logic [3:0]                ck_div64,
  output logic      [3:0]                aux_clock_outputs,
  input  wire logic                      mon_enable,
  input  wire logic                      mon_unity_gain,
  output logic                           mon_active,
  output logic                           rx_adapt_en,
  output logic                           dfe_zero
);
  import rcd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_C = (AW+1)'(DEPTH);
  localparam logic [AW:0]   HALF_C = (AW+1)'(DEPTH / 2);
  localparam logic [AW-1:0] LAST_P = AW'(DEPTH - 1);
  localparam logic [3:0]    SQ_LAST = 4'(SQ_RUN - 1);

  typedef struct packed {
    logic                          rate_cap;
    logic                          ref125;
    logic                          refbad;
    rcd_mode_t                     mode;
    rcd_an_state_t                 an;
    logic [1:0]                    pabil;
    logic [1:0][DEPTH-1:0][DW-1:0] mem;
    logic [1:0][AW-1:0]            wp;
    logic [1:0][AW-1:0]            rp;
    logic [1:0][AW:0]              cnt;
    logic [1:0]                    primed;
    logic [1:0]                    slip;
    logic [1:0][TW-1:0]            lpf;
    logic [2:0]                    taps;
    logic [3:0]                    sq_cnt;
    logic                          sq_bit;
    logic signed [7:0]             fir;
    logic [3:0][5:0]               ckdiv;
    logic [3:0]                    ckout;
  } rcd_state_t;

  rcd_state_t s_r;
  rcd_state_t s_nxt;

  logic [1:0]          can_push;
  logic [1:0]          push;
  logic [1:0]          pop;
  logic [1:0]          src_v;
  logic [1:0][DW-1:0]  src_d;
  logic [3:0]          ck_evt;
  logic [1:0]          common;
  logic                mode_chg;
  logic signed [TW-1:0] err_x;
  logic signed [TW-1:0] lpf_s;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == LAST_P) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  function automatic logic signed [7:0] tap_wt(input logic b,
                                               input logic signed [5:0] c);
    return b ? 8'(c) : -8'(c);
  endfunction : tap_wt

  function automatic logic [5:0] half_div(input logic d64);
    return d64 ? 6'(DIV_LONG / 7'h02) : 6'(DIV_SHORT / 7'h02);
  endfunction : half_div

  function automatic logic is_10g(input rcd_mode_t m);
    return m != RCD_GBE;
  endfunction : is_10g

  //////////////////////////////////////////////////////////////////////////
  // source routing into buffers; buffer t feeds serializer of side t
  always_comb begin
    src_v = '0;
    src_d = rx_data;
    // toward line serializer
    if (line_pma_loopback) begin
      src_v[SIDE_LINE] = rx_valid[SIDE_LINE];
      src_d[SIDE_LINE] = rx_data[SIDE_LINE];
    end else if (!host_pma_loopback) begin
      src_v[SIDE_LINE] = rx_valid[SIDE_HOST];
      src_d[SIDE_LINE] = rx_data[SIDE_HOST];
    end
    // toward host serializer
    if (host_pma_loopback) begin
      src_v[SIDE_HOST] = rx_valid[SIDE_HOST];
      src_d[SIDE_HOST] = rx_data[SIDE_HOST];
    end else if (!line_pma_loopback) begin
      src_v[SIDE_HOST] = rx_valid[SIDE_LINE];
      src_d[SIDE_HOST] = rx_data[SIDE_LINE];
    end
    for (int t = 0; t < 2; t++) begin
      can_push[t] = s_r.cnt[t] != FULL_C;
      push[t]     = src_v[t] && can_push[t];
      pop[t]      = tx_valid[t] && tx_ready[t];
    end
    // a side whose data is looped away elsewhere is drained, not stalled
    if (line_pma_loopback)
      rx_ready[SIDE_LINE] = can_push[SIDE_LINE];
    else if (host_pma_loopback)
      rx_ready[SIDE_LINE] = 1'b1;
    else
      rx_ready[SIDE_LINE] = can_push[SIDE_HOST];
    if (host_pma_loopback)
      rx_ready[SIDE_HOST] = can_push[SIDE_HOST];
    else if (line_pma_loopback)
      rx_ready[SIDE_HOST] = 1'b1;
    else
      rx_ready[SIDE_HOST] = can_push[SIDE_LINE];
    ck_evt[CK_LINE_RX] = rx_valid[SIDE_LINE] && rx_ready[SIDE_LINE];
    ck_evt[CK_HOST_RX] = rx_valid[SIDE_HOST] && rx_ready[SIDE_HOST];
    ck_evt[CK_LINE_TX] = pop[SIDE_LINE];
    ck_evt[CK_HOST_TX] = pop[SIDE_HOST];
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt    = s_r;
    common   = s_r.pabil & an_local_abil;
    mode_chg = 1'b0;
    err_x    = '0;
    lpf_s    = '0;

    // reference rate pins caught once, first cycle after reset release
    if (!s_r.rate_cap) begin
      s_nxt.rate_cap = 1'b1;
      s_nxt.ref125   = rate_sel_hi && !rate_sel_lo;
      s_nxt.refbad   = rate_sel_lo;
    end

    // negotiation; side choice is a single bit so both never run
    case (s_r.an)
      RCD_AN_IDLE: begin
        if (an_enable)
          s_nxt.an = RCD_AN_WAIT;
      end
      RCD_AN_WAIT: begin
        if (an_page_valid) begin
          s_nxt.pabil = an_partner_abil;
          s_nxt.an    = RCD_AN_RESOLVE;
        end else if (an_pd_valid) begin
          if (an_pd_10g && an_local_abil[AB_10G]) begin
            s_nxt.mode = RCD_LAN;
            s_nxt.an   = RCD_AN_GOOD;
          end else if (!an_pd_10g && an_local_abil[AB_1G]) begin
            s_nxt.mode = RCD_GBE;
            s_nxt.an   = RCD_AN_GOOD;
          end
        end
      end
      RCD_AN_RESOLVE: begin
        // highest shared rate wins; nothing shared goes back to listening
        if (common[AB_10G]) begin
          s_nxt.mode = RCD_LAN;
          s_nxt.an   = RCD_AN_GOOD;
        end else if (common[AB_1G]) begin
          s_nxt.mode = RCD_GBE;
          s_nxt.an   = RCD_AN_GOOD;
        end else begin
          s_nxt.an = RCD_AN_WAIT;
        end
      end
      RCD_AN_GOOD: begin
        if (an_link_fail)
          s_nxt.an = RCD_AN_WAIT;
      end
      default: s_nxt.an = RST_AN;
    endcase
    if (!an_enable) begin
      s_nxt.an = RCD_AN_IDLE;
      if (cfg_mode <= RCD_OTU2E)
        s_nxt.mode = cfg_mode;
    end
    mode_chg = s_nxt.mode != s_r.mode;

    // elastic buffers, one per direction
    for (int t = 0; t < 2; t++) begin
      s_nxt.slip[t] = 1'b0;
      if (push[t]) begin
        s_nxt.mem[t][s_r.wp[t]] = src_d[t];
        s_nxt.wp[t] = ptr_inc(s_r.wp[t]);
      end
      if (pop[t])
        s_nxt.rp[t] = ptr_inc(s_r.rp[t]);
      s_nxt.cnt[t] = (AW+1)'(s_r.cnt[t] + {AW'(0), push[t]}
                             - {AW'(0), pop[t]});
      // output held back until half full so both slips have margin
      if (!s_r.primed[t] && s_r.cnt[t] >= HALF_C)
        s_nxt.primed[t] = 1'b1;
      // serializer asked while empty: re-centre by refilling to half
      if (s_r.primed[t] && s_r.cnt[t] == '0 && tx_ready[t]) begin
        s_nxt.primed[t] = 1'b0;
        s_nxt.slip[t]   = 1'b1;
      end
      // fill error steers the transmit clock trim through a leaky sum
      err_x = TW'($signed({1'b0, s_r.cnt[t]}) - $signed({1'b0, HALF_C}));
      lpf_s = $signed(s_r.lpf[t]);
      s_nxt.lpf[t] = TW'(lpf_s + err_x - (lpf_s >>> LPF_SHIFT));
      // rate change: words in flight belong to the old rate
      if (mode_chg) begin
        s_nxt.wp[t]     = '0;
        s_nxt.rp[t]     = '0;
        s_nxt.cnt[t]    = '0;
        s_nxt.primed[t] = 1'b0;
        s_nxt.slip[t]   = 1'b1;
        s_nxt.lpf[t]    = '0;
      end
    end

    // square wave test source
    if (s_r.sq_cnt == SQ_LAST) begin
      s_nxt.sq_cnt = '0;
      s_nxt.sq_bit = !s_r.sq_bit;
    end else begin
      s_nxt.sq_cnt = 4'(s_r.sq_cnt + 4'h1);
    end

    // three-flop delay line; taps[0] is pre, [1] main, [2] post
    s_nxt.taps = {s_r.taps[1:0],
                  tx_square_en ? s_r.sq_bit : tx_ser_bit};
    s_nxt.fir  = 8'(tap_wt(s_r.taps[0], coef_pre)
                  + tap_wt(s_r.taps[1], coef_main)
                  + tap_wt(s_r.taps[2], coef_post));

    // divided clock outputs, counting word strobes of the chosen source
    for (int k = 0; k < 4; k++) begin
      if (ck_evt[ck_src_sel[k]]) begin
        if (s_r.ckdiv[k] >= 6'(half_div(ck_div64[k]) - 6'h01)) begin
          s_nxt.ckdiv[k] = '0;
          s_nxt.ckout[k] = !s_r.ckout[k];
        end else begin
          s_nxt.ckdiv[k] = 6'(s_r.ckdiv[k] + 6'h01);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r      <= '0;
      s_r.mode <= RST_MODE;
      s_r.an   <= RST_AN;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      tx_valid[t] = s_r.primed[t] && (s_r.cnt[t] != '0);
      tx_data[t]  = s_r.mem[t][s_r.rp[t]];
    end
  end

  assign tx_trim        = s_r.lpf;
  assign eb_recentre    = s_r.slip;
  assign ref_is_125     = s_r.ref125;
  assign ref_sel_bad    = s_r.refbad;
  assign an_line_active = an_enable && !an_on_host;
  assign an_host_active = an_enable && an_on_host;
  assign an_done        = s_r.an == RCD_AN_GOOD;
  // one mode register serves both sides and both subsections
  assign line_rate_mode = s_r.mode;
  assign host_rate_mode = s_r.mode;
  assign clock_recovery_unit_10g = is_10g(s_r.mode);
  assign fir_clk_10g    = is_10g(s_r.mode);
  assign fir_level      = s_r.fir;
  assign aux_clock_outputs = s_r.ckout;
  // monitor has no meaning at 1G
  assign mon_active     = mon_enable && is_10g(s_r.mode);
  assign dfe_zero       = mon_active && mon_unity_gain;
  assign rx_adapt_en    = !(mon_active && mon_unity_gain);

endmodule : rcd_channel_datapath

`default_nettype wire

// ### rcd_channel_datapath_asserts.sv
// checker: port-level properties of the retimer channel datapath
`timescale 1ns/1ps
`default_nettype none

module rcd_channel_datapath_asserts #(
  parameter int DW = 20
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               ref_is_125,
  input wire logic [1:0][DW-1:0] tx_data,
  input wire logic [1:0]         tx_valid,
  input wire logic [1:0]         tx_ready,
  input wire logic [1:0]         eb_recentre,
  input wire rcd_pkg::rcd_mode_t cfg_mode,
  input wire logic               an_enable,
  input wire logic               an_on_host,
  input wire logic               an_line_active,
  input wire logic               an_host_active,
  input wire rcd_pkg::rcd_mode_t line_rate_mode,
  input wire rcd_pkg::rcd_mode_t host_rate_mode,
  input wire logic               clock_recovery_unit_10g,
  input wire logic               fir_clk_10g,
  input wire logic               mon_unity_gain,
  input wire logic               mon_active,
  input wire logic               rx_adapt_en,
  input wire logic               dfe_zero
);
  import rcd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // two edges past release, so the sampling edge itself is not judged
  logic [1:0] up_r;
  always_ff @(posedge clk) begin
    up_r <= rst_n ? {up_r[0], 1'b1} : 2'h0;
  end

  sequence s_held;
    tx_valid[0] && !tx_ready[0] ##1 $stable(line_rate_mode);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  ref_hold_a: assert property (up_r[1] |-> $stable(ref_is_125))
    else $error("reference rate choice moved after sampling");
  an_side_a: assert property (an_enable |->
    an_host_active == an_on_host && an_line_active == !an_on_host)
    else $error("negotiation active on the wrong side");
  mode_pair_a: assert property (line_rate_mode == host_rate_mode)
    else $error("line and host modes differ");
  cru_rate_a: assert property (
    clock_recovery_unit_10g == (line_rate_mode != RCD_GBE))
    else $error("recovery rate does not follow mode");
  fir_clk_a: assert property (fir_clk_10g != (host_rate_mode == RCD_GBE))
    else $error("tap clock does not follow mode");
  mon_10g_a: assert property (mon_active |-> line_rate_mode != RCD_GBE)
    else $error("monitor active outside 10G");
  unity_gain_a: assert property (mon_active && mon_unity_gain |->
    !rx_adapt_en && dfe_zero)
    else $error("unity gain left adaptation running");
  word_hold_a: assert property (s_held |->
    tx_valid[0] && $stable(tx_data[0]))
    else $error("stalled word dropped or changed");
  flush_mark_a: assert property (!$stable(line_rate_mode) |->
    eb_recentre == 2'h3)
    else $error("rate change without recentre");
  forced_mode_a: assert property ($past(rst_n) && !$past(an_enable) &&
    $past(cfg_mode) <= RCD_OTU2E |-> line_rate_mode == $past(cfg_mode))
    else $error("forced mode not applied");
endmodule : rcd_channel_datapath_asserts

bind rcd_channel_datapath rcd_channel_datapath_asserts #(.DW(DW))
  rcd_channel_datapath_asserts_inst (
  .clk(clk), .rst_n(rst_n), .ref_is_125(ref_is_125), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .eb_recentre(eb_recentre),
  .cfg_mode(cfg_mode), .an_enable(an_enable), .an_on_host(an_on_host),
  .an_line_active(an_line_active), .an_host_active(an_host_active),
  .line_rate_mode(line_rate_mode), .host_rate_mode(host_rate_mode),
  .clock_recovery_unit_10g(clock_recovery_unit_10g),
  .fir_clk_10g(fir_clk_10g), .mon_unity_gain(mon_unity_gain),
  .mon_active(mon_active), .rx_adapt_en(rx_adapt_en), .dfe_zero(dfe_zero));

`default_nettype wire

// ### rcd_ser_model.sv
// far-side serializer model: collects words, may stall
`timescale 1ns/1ps
`default_nettype none

module rcd_ser_model #(
  parameter int DW = 20
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          valid,
  input  wire logic [DW-1:0] data,
  input  wire logic          stall,
  output logic               ready
);
  logic [DW-1:0] q [$];
  // a live serializer pulls every cycle, so gaps show as underflow
  assign ready = rst_n && !stall;
  always @(posedge clk) begin
    if (valid && ready) begin
      q.push_back(data);
    end
  end
endmodule : rcd_ser_model

`default_nettype wire

// ### rcd_channel_datapath_tb.sv
// testbench: directed sequences over the retimer channel datapath
`timescale 1ns/1ps
`default_nettype none

module rcd_channel_datapath_tb;
  import rcd_pkg::*;
  logic              clk, rst_n, rate_sel_hi, rate_sel_lo, ref_is_125;
  logic              ref_sel_bad, line_pma_loopback, host_pma_loopback;
  logic [1:0][19:0]  rx_data, tx_data;
  logic [1:0]        rx_valid, rx_ready, tx_valid, tx_ready, eb_recentre;
  logic [1:0]        stall, an_local_abil, an_partner_abil;
  logic [1:0][11:0]  tx_trim;
  rcd_mode_t         cfg_mode, line_rate_mode, host_rate_mode;
  logic              an_enable, an_on_host, an_page_valid, an_pd_valid;
  logic              an_pd_10g, an_link_fail, an_line_active, an_host_active;
  logic              an_done, clock_recovery_unit_10g, fir_clk_10g;
  logic              tx_ser_bit, tx_square_en, mon_enable, mon_unity_gain;
  logic              mon_active, rx_adapt_en, dfe_zero;
  logic signed [5:0] coef_pre, coef_main, coef_post;
  logic signed [7:0] fir_level;
  logic [3:0][1:0]   ck_src_sel;
  logic [3:0]        ck_div64, aux_clock_outputs;
  int                num_errors = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                sq_ones = 0;

  rcd_channel_datapath rcd_channel_datapath_inst (
    .clk(clk), .rst_n(rst_n), .rate_sel_hi(rate_sel_hi),
    .rate_sel_lo(rate_sel_lo), .ref_is_125(ref_is_125),
    .ref_sel_bad(ref_sel_bad), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_trim(tx_trim), .eb_recentre(eb_recentre),
    .line_pma_loopback(line_pma_loopback),
    .host_pma_loopback(host_pma_loopback), .cfg_mode(cfg_mode),
    .an_enable(an_enable), .an_on_host(an_on_host),
    .an_local_abil(an_local_abil), .an_page_valid(an_page_valid),
    .an_partner_abil(an_partner_abil), .an_pd_valid(an_pd_valid),
    .an_pd_10g(an_pd_10g), .an_link_fail(an_link_fail),
    .an_line_active(an_line_active), .an_host_active(an_host_active),
    .an_done(an_done), .line_rate_mode(line_rate_mode),
    .host_rate_mode(host_rate_mode),
    .clock_recovery_unit_10g(clock_recovery_unit_10g),
    .tx_ser_bit(tx_ser_bit), .tx_square_en(tx_square_en),
    .coef_pre(coef_pre), .coef_main(coef_main), .coef_post(coef_post),
    .fir_level(fir_level), .fir_clk_10g(fir_clk_10g),
    .ck_src_sel(ck_src_sel), .ck_div64(ck_div64),
    .aux_clock_outputs(aux_clock_outputs), .mon_enable(mon_enable),
    .mon_unity_gain(mon_unity_gain), .mon_active(mon_active),
    .rx_adapt_en(rx_adapt_en), .dfe_zero(dfe_zero));

  rcd_ser_model rcd_ser_model_inst [1:0] (.clk(clk), .rst_n(rst_n),
    .valid(tx_valid), .data(tx_data), .stall(stall), .ready(tx_ready));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // holds valid afterwards so back-to-back words need no gap
  task automatic send(input int s, input logic [19:0] w);
    rx_data[s] = w;
    rx_valid[s] = 1'b1;
    #1;
    while (rx_ready[s] !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(negedge clk);
  endtask : send

  task automatic relink;
    an_link_fail = 1'b1;
    @(negedge clk);
    an_link_fail = 1'b0;
    @(negedge clk);
  endtask : relink

  task automatic wait_done;
    for (int n = 0; n < 20 && an_done !== 1'b1; n++) begin
      @(negedge clk);
    end
    chk(20'(an_done), 20'h1);
  endtask : wait_done

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, rx_valid, line_pma_loopback, host_pma_loopback, an_enable} = '0;
    {an_on_host, an_page_valid, an_pd_valid, an_pd_10g, an_link_fail} = '0;
    {tx_square_en, rate_sel_lo, mon_enable, stall} = '0;
    {rate_sel_hi, mon_unity_gain, tx_ser_bit} = 3'h7;
    rx_data = '0;
    cfg_mode = RCD_LAN;
    {an_local_abil, an_partner_abil} = 4'hD;
    {coef_pre, coef_main, coef_post} = {6'h3E, 6'h0C, 6'h3D};
    ck_src_sel = {CK_HOST_TX, CK_HOST_RX, CK_LINE_RX, CK_LINE_RX};
    ck_div64 = 4'h2;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(20'(ref_is_125), 20'h1);
    chk(20'(ref_sel_bad), 20'h0);
    chk(20'(fir_level), 20'h00007);
    tx_ser_bit = 1'b0;
    repeat (2) @(negedge clk);
    chk(20'(fir_level), 20'h0000B);
    repeat (4) @(negedge clk);
    chk(20'(fir_level), 20'hFFFF9);
    // one full period: a run of eight ones fills all taps six times
    tx_square_en = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      if (fir_level == 8'sh07) sq_ones++;
    end
    chk(20'(sq_ones), 20'h00006);
    tx_square_en = 1'b0;
    mon_enable = 1'b1;
    an_enable = 1'b1;
    #1 chk(20'({an_line_active, an_host_active}), 20'h2);
    @(negedge clk);
    {an_on_host, an_page_valid} = 2'h3;
    #1 chk(20'({an_line_active, an_host_active}), 20'h1);
    wait_done;
    chk(20'(line_rate_mode), 20'(RCD_GBE));
    chk(20'({clock_recovery_unit_10g, fir_clk_10g, mon_active}), 20'h0);
    an_partner_abil = 2'h3;
    relink;
    wait_done;
    chk(20'(line_rate_mode), 20'(RCD_LAN));
    chk(20'({mon_active, dfe_zero, rx_adapt_en}), 20'h6);
    {an_local_abil, an_partner_abil} = 4'h6;
    relink;
    repeat (12) @(negedge clk);
    chk(20'(an_done), 20'h0);
    {an_page_valid, an_pd_valid} = 2'h1;
    wait_done;
    chk(20'(host_rate_mode), 20'(RCD_GBE));
    {an_enable, an_pd_valid} = 2'h0;
    for (int i = 0; i < 6; i++) begin
      cfg_mode = rcd_mode_t'(i);
      repeat (3) @(negedge clk);
      chk(20'(line_rate_mode), 20'((i > 4) ? 4 : i));
      chk(20'(host_rate_mode), 20'((i > 4) ? 4 : i));
    end
    for (int i = 0; i < 32; i++) begin
      send(0, 20'hA5000 + 20'(i));
      if (i == 15) chk(20'(aux_clock_outputs[2:0]), 20'h1);
    end
    rx_valid[0] = 1'b0;
    chk(20'(aux_clock_outputs[2:0]), 20'h2);
    repeat (8) @(negedge clk);
    chk(20'(rcd_ser_model_inst[1].q.size()), 20'h20);
    for (int i = 0; i < 32; i++) begin
      chk(rcd_ser_model_inst[1].q.pop_front(), 20'hA5000 + 20'(i));
    end
    stall[0] = 1'b1;
    send(1, 20'h5A001);
    send(1, 20'h5A002);
    rx_data[1] = 20'h5A003;
    #1 chk(20'(rx_ready[1]), 20'h0);
    repeat (4) @(negedge clk);
    chk(20'(tx_trim[0]), 20'h00004);
    stall[0] = 1'b0;
    send(1, 20'h5A003);
    rx_valid[1] = 1'b0;
    repeat (8) @(negedge clk);
    chk(20'(rcd_ser_model_inst[0].q.size()), 20'h3);
    for (int i = 1; i < 4; i++) begin
      chk(rcd_ser_model_inst[0].q.pop_front(), 20'h5A000 + 20'(i));
    end
    line_pma_loopback = 1'b1;
    send(0, 20'h3C001);
    rx_valid[0] = 1'b0;
    repeat (4) @(negedge clk);
    chk(20'(rcd_ser_model_inst[1].q.size()), 20'h0);
    chk(rcd_ser_model_inst[0].q.pop_front(), 20'h3C001);
    {line_pma_loopback, host_pma_loopback} = 2'h1;
    send(1, 20'h3C002);
    rx_valid[1] = 1'b0;
    repeat (4) @(negedge clk);
    chk(20'(rcd_ser_model_inst[0].q.size()), 20'h0);
    chk(rcd_ser_model_inst[1].q.pop_front(), 20'h3C002);
    // 10G partner without pages, found by parallel detection
    {an_local_abil, an_pd_10g, an_pd_valid, an_enable} = 5'h17;
    wait_done;
    chk(20'(line_rate_mode), 20'(RCD_LAN));
    report_and_stop;
  end
endmodule : rcd_channel_datapath_tb

`default_nettype wire
